// >>> ocrs_params.svh
`ifndef OCRS_PARAMS_SVH
`define OCRS_PARAMS_SVH

// Register byte offsets
`define OCRS_A_MAIN_CTRL 12'h000
`define OCRS_A_AUX_CTRL 12'h004
`define OCRS_A_OUTPUT_CFG_REG_1 12'h008
`define OCRS_A_OCR2 12'h00C
`define OCRS_A_OCR3 12'h010
`define OCRS_A_OUTPUT_CFG_REG_4 12'h014
`define OCRS_A_FSC 12'h018
`define OCRS_A_MAIN_STAT 12'h01C
`define OCRS_A_AUX_STAT 12'h020
`define OCRS_A_ERR_STAT 12'h024

// Field positions in main_path_ctrl_1
`define OCRS_F_MSEL 2:0
`define OCRS_F_FOLLOW 3
`define OCRS_F_M2A 6:4
// Field positions in aux_path_ctrl_1
`define OCRS_F_ASEL 3:0
`define OCRS_F_ADFB 4
// Field positions in the error status word
`define OCRS_F_E_MAIN 0
`define OCRS_F_E_AUX 1
`define OCRS_F_E_M2A 2
`define OCRS_F_E_DFB 3
`define OCRS_F_E_OUT 10:4

// Reset values
`define OCRS_RST_MCTL 7'h00
`define OCRS_RST_ACTL 5'h00
`define OCRS_RST_OCR 28'h0000000
`define OCRS_RST_FSC 1'h0

// APLL rates in kHz
`define OCRS_KHZ_NONE 19'h00000
`define OCRS_KHZ_311040 19'h4BF00
`define OCRS_KHZ_98304 19'h18000
`define OCRS_KHZ_131072 19'h20000
`define OCRS_KHZ_148224 19'h24300
`define OCRS_KHZ_98816 19'h18200
`define OCRS_KHZ_100992 19'h18A80
`define OCRS_KHZ_274944 19'h43200
`define OCRS_KHZ_178944 19'h2BB00
`define OCRS_KHZ_250000 19'h3D090

// Main rate codes
`define OCRS_M_77D 3'h0
`define OCRS_M_77A 3'h1
`define OCRS_M_12E1 3'h2
`define OCRS_M_16E1 3'h3
`define OCRS_M_24DS1 3'h4
`define OCRS_M_16DS1 3'h5
`define OCRS_M_6312 3'h6

// Aux rate codes
`define OCRS_X_SQL 4'h0
`define OCRS_X_NORM 4'h1
`define OCRS_X_12E1 4'h2
`define OCRS_X_16E1 4'h3
`define OCRS_X_24DS1 4'h4
`define OCRS_X_16DS1 4'h5
`define OCRS_X_2E3 4'h6
`define OCRS_X_DS3 4'h7
`define OCRS_X_6312 4'h8
`define OCRS_X_GBE 4'h9

// Main-to-aux source codes
`define OCRS_T_12E1 3'h0
`define OCRS_T_16E1 3'h2
`define OCRS_T_24DS1 3'h4
`define OCRS_T_16DS1 3'h6
`define OCRS_T_6312 3'h7

// Output rate codes
`define OCRS_O_OFF 4'h0
`define OCRS_O_2K 4'h1
`define OCRS_O_8K 4'h2
`define OCRS_O_DFSB 4'h3
`define OCRS_O_DFSA 4'h4
`define OCRS_O_M48 4'h5
`define OCRS_O_M16 4'h6
`define OCRS_O_M12 4'h7
`define OCRS_O_M8 4'h8
`define OCRS_O_M6 4'h9
`define OCRS_O_M4 4'hA
`define OCRS_O_A64 4'hB
`define OCRS_O_A48 4'hC
`define OCRS_O_A16 4'hD
`define OCRS_O_A8 4'hE
`define OCRS_O_A4 4'hF

// Divider ratios
`define OCRS_DIV_0 7'h00
`define OCRS_DIV_1 7'h01
`define OCRS_DIV_2 7'h02
`define OCRS_DIV_4 7'h04
`define OCRS_DIV_6 7'h06
`define OCRS_DIV_8 7'h08
`define OCRS_DIV_12 7'h0C
`define OCRS_DIV_16 7'h10
`define OCRS_DIV_48 7'h30
`define OCRS_DIV_64 7'h40

// Outputs with exceptions
`define OCRS_OC4 4
`define OCRS_OC5 5
`define OCRS_OC6 6
`define OCRS_OC7 7

`endif

// >>> ocrs_pkg.sv
package ocrs_pkg;
	// Source chosen for one general output clock
	typedef enum logic [3:0] {
		OCRS_SRC_OFF = 4'h0,
		OCRS_SRC_MAIN_2K = 4'h1,
		OCRS_SRC_MAIN_8K = 4'h2,
		OCRS_SRC_AUX_2K = 4'h3,
		OCRS_SRC_AUX_8K = 4'h4,
		OCRS_SRC_DFS_B = 4'h5,
		OCRS_SRC_DFS_A = 4'h6,
		OCRS_SRC_MAIN = 4'h7,
		OCRS_SRC_AUX = 4'h8
	} ocrs_src_e;
	// APLL rate in kHz
	typedef logic [18:0] ocrs_khz_t;
	// Divider ratio
	typedef logic [6:0] ocrs_div_t;
endpackage

// >>> ocrs_oc_if.sv
`timescale 1ns/100ps
interface ocrs_oc_if;
	logic [3:0] code; // Output rate field
	ocrs_pkg::ocrs_khz_t main_khz; // Main APLL rate
	ocrs_pkg::ocrs_khz_t aux_khz; // Aux APLL rate
	logic frame_aux; // Low rates from aux path
	ocrs_pkg::ocrs_src_e src; // Decoded source
	ocrs_pkg::ocrs_div_t div; // Decoded divider
	logic unav; // Ratio not available
	modport cfg (output code, main_khz, aux_khz, frame_aux, input src, div, unav);
	modport dec (input code, main_khz, aux_khz, frame_aux, output src, div, unav);
endinterface

// >>> ocrs_out_dec.sv
`timescale 1ns/100ps
`include "ocrs_params.svh"
module ocrs_out_dec #(
	parameter int OUT_IDX = 1
) (
	// Field in, decode out
	ocrs_oc_if.dec oc
);
	logic use_main; // Division of main APLL
	logic use_aux; // Division of aux APLL
	ocrs_pkg::ocrs_div_t div_raw; // Ratio before checks
	ocrs_pkg::ocrs_khz_t rate; // Rate of chosen path
	logic bad_rate; // Rate lacks /6 and /12

	// Field decode with per-output exceptions
	always_comb begin
		use_main = 1'b0;
		use_aux = 1'b0;
		div_raw = `OCRS_DIV_0;
		oc.src = ocrs_pkg::OCRS_SRC_OFF;
		case (oc.code)
			`OCRS_O_OFF: oc.src = ocrs_pkg::OCRS_SRC_OFF;
			// Low rates follow the frame source bit
			`OCRS_O_2K: oc.src = oc.frame_aux ? ocrs_pkg::OCRS_SRC_AUX_2K :
				ocrs_pkg::OCRS_SRC_MAIN_2K;
			`OCRS_O_8K: oc.src = oc.frame_aux ? ocrs_pkg::OCRS_SRC_AUX_8K :
				ocrs_pkg::OCRS_SRC_MAIN_8K;
			`OCRS_O_DFSB: begin
				if (OUT_IDX == `OCRS_OC6) begin
					use_main = 1'b1;
					div_raw = `OCRS_DIV_2;
				end else begin
					oc.src = ocrs_pkg::OCRS_SRC_DFS_B;
				end
			end
			`OCRS_O_DFSA: begin
				if (OUT_IDX == `OCRS_OC7) begin
					use_main = 1'b1;
					div_raw = `OCRS_DIV_2;
				end else begin
					oc.src = ocrs_pkg::OCRS_SRC_DFS_A;
				end
			end
			`OCRS_O_M48: begin
				use_main = 1'b1;
				div_raw = (OUT_IDX == `OCRS_OC6) ? `OCRS_DIV_1 : `OCRS_DIV_48;
			end
			`OCRS_O_M16: begin
				use_main = 1'b1;
				div_raw = `OCRS_DIV_16;
			end
			`OCRS_O_M12: begin
				use_main = 1'b1;
				div_raw = `OCRS_DIV_12;
			end
			`OCRS_O_M8: begin
				use_main = 1'b1;
				div_raw = `OCRS_DIV_8;
			end
			`OCRS_O_M6: begin
				use_main = 1'b1;
				div_raw = `OCRS_DIV_6;
			end
			`OCRS_O_M4: begin
				use_main = 1'b1;
				div_raw = `OCRS_DIV_4;
			end
			`OCRS_O_A64: begin
				use_aux = 1'b1;
				div_raw = (OUT_IDX == `OCRS_OC4 || OUT_IDX == `OCRS_OC5) ?
					`OCRS_DIV_2 : `OCRS_DIV_64;
			end
			`OCRS_O_A48: begin
				use_aux = 1'b1;
				div_raw = `OCRS_DIV_48;
			end
			`OCRS_O_A16: begin
				use_aux = 1'b1;
				div_raw = `OCRS_DIV_16;
			end
			`OCRS_O_A8: begin
				use_aux = 1'b1;
				div_raw = `OCRS_DIV_8;
			end
			default: begin
				use_aux = 1'b1;
				div_raw = `OCRS_DIV_4;
			end
		endcase
		// Divided sources name their path
		if (use_main) begin
			oc.src = ocrs_pkg::OCRS_SRC_MAIN;
		end
		if (use_aux) begin
			oc.src = ocrs_pkg::OCRS_SRC_AUX;
		end
	end

	// Path rate and the missing-ratio check
	always_comb begin
		rate = use_main ? oc.main_khz : (use_aux ? oc.aux_khz : `OCRS_KHZ_NONE);
		bad_rate = (rate == `OCRS_KHZ_274944) || (rate == `OCRS_KHZ_250000) ||
			(rate == `OCRS_KHZ_178944);
		oc.unav = (use_main || use_aux) && bad_rate &&
			(div_raw == `OCRS_DIV_6 || div_raw == `OCRS_DIV_12);
		oc.div = `OCRS_DIV_0;
		if ((use_main || use_aux) && !oc.unav && rate != `OCRS_KHZ_NONE) begin
			oc.div = div_raw;
		end
	end
endmodule

// >>> ocrs_top.sv
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "ocrs_params.svh"
module ocrs_top #(
	parameter int N_OUT = 7
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Main path decode
	output logic [18:0] main_apll_khz,
	output logic main_analog_fb,
	// Aux path decode
	output logic [18:0] aux_apll_khz,
	output logic [18:0] aux_fwd_khz,
	output logic aux_squelch,
	output logic aux_from_main,
	output logic aux_dig_fb,
	// Output clock decode
	output logic frame_from_aux,
	output logic [4*N_OUT-1:0] out_src,
	output logic [7*N_OUT-1:0] out_div
);
	// Software registers
	logic [6:0] mctl_q, mctl_d; // main_path_ctrl_1
	logic [4:0] actl_q, actl_d; // aux_path_ctrl_1
	logic [27:0] ocr_q, ocr_d; // output_cfg_reg_1..4
	logic fsc_q, fsc_d; // frame_sync_ctrl_1
	// APB answer
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	// Decoded path state
	logic [18:0] main_khz_q, main_khz_d;
	logic main_afb_q, main_afb_d;
	logic [18:0] aux_khz_q, aux_khz_d;
	logic [18:0] fwd_khz_q, fwd_khz_d;
	logic sql_q, sql_d;
	logic follow_q, follow_d;
	logic adfb_q, adfb_d;
	logic frame_q, frame_d;
	logic [10:0] err_q, err_d; // Error status
	logic [4*N_OUT-1:0] src_q, src_d;
	logic [7*N_OUT-1:0] div_q, div_d;
	// Bus helpers
	logic wr_en; // Write at end of access
	logic setup; // Setup cycle
	logic mapped; // Address decodes
	logic [31:0] rd_mux; // Read value
	logic [N_OUT-1:0] unav; // Per-output missing ratio

	ocrs_oc_if oc_if[N_OUT] ();

	// One decoder per general output
	genvar gi;
	generate
		for (gi = 0; gi < N_OUT; gi++) begin : g_oc
			assign oc_if[gi].code = ocr_q[4*gi +: 4];
			assign oc_if[gi].main_khz = main_khz_q;
			assign oc_if[gi].aux_khz = aux_khz_q;
			assign oc_if[gi].frame_aux = frame_q;
			assign src_d[4*gi +: 4] = oc_if[gi].src;
			assign div_d[7*gi +: 7] = oc_if[gi].div;
			assign unav[gi] = oc_if[gi].unav;
			ocrs_out_dec #(
				.OUT_IDX(gi + 1)
			) u_dec (
				.oc(oc_if[gi])
			);
		end
	endgenerate

	// Address decode and read mux
	always_comb begin
		mapped = 1'b1;
		rd_mux = 32'h00000000;
		case (paddr)
			`OCRS_A_MAIN_CTRL: rd_mux = {25'h0000000, mctl_q};
			`OCRS_A_AUX_CTRL: rd_mux = {27'h0000000, actl_q};
			`OCRS_A_OUTPUT_CFG_REG_1: rd_mux = {24'h000000, ocr_q[7:0]};
			`OCRS_A_OCR2: rd_mux = {24'h000000, ocr_q[15:8]};
			`OCRS_A_OCR3: rd_mux = {24'h000000, ocr_q[23:16]};
			`OCRS_A_OUTPUT_CFG_REG_4: rd_mux = {28'h0000000, ocr_q[27:24]};
			`OCRS_A_FSC: rd_mux = {31'h00000000, fsc_q};
			`OCRS_A_MAIN_STAT: rd_mux = {12'h000, main_afb_q, main_khz_q};
			`OCRS_A_AUX_STAT: rd_mux = {11'h000, follow_q, sql_q, aux_khz_q};
			`OCRS_A_ERR_STAT: rd_mux = {21'h000000, err_q};
			default: mapped = 1'b0;
		endcase
	end

	// APB answer: ready in the access cycle, zero wait
	always_comb begin
		setup = psel && !penable;
		wr_en = psel && penable && pready_q && pwrite && !pslverr_q;
		pready_d = setup;
		pslverr_d = setup && !mapped;
		prdata_d = prdata_q;
		if (setup) begin
			prdata_d = (pwrite || !mapped) ? 32'h00000000 : rd_mux;
		end
	end

	// Register writes
	always_comb begin
		mctl_d = mctl_q;
		actl_d = actl_q;
		ocr_d = ocr_q;
		fsc_d = fsc_q;
		if (wr_en) begin
			case (paddr)
				`OCRS_A_MAIN_CTRL: mctl_d = pwdata[6:0];
				`OCRS_A_AUX_CTRL: actl_d = pwdata[4:0];
				`OCRS_A_OUTPUT_CFG_REG_1: ocr_d[7:0] = pwdata[7:0];
				`OCRS_A_OCR2: ocr_d[15:8] = pwdata[7:0];
				`OCRS_A_OCR3: ocr_d[23:16] = pwdata[7:0];
				`OCRS_A_OUTPUT_CFG_REG_4: ocr_d[27:24] = pwdata[3:0];
				`OCRS_A_FSC: fsc_d = pwdata[0];
				default: mctl_d = mctl_q;
			endcase
		end
	end

	// Main and aux path rate decode
	always_comb begin
		main_afb_d = 1'b0;
		main_khz_d = `OCRS_KHZ_311040;
		err_d = 11'h000;
		case (mctl_q[`OCRS_F_MSEL])
			`OCRS_M_77D: main_khz_d = `OCRS_KHZ_311040;
			`OCRS_M_77A: begin
				main_khz_d = `OCRS_KHZ_311040;
				main_afb_d = 1'b1;
			end
			`OCRS_M_12E1: main_khz_d = `OCRS_KHZ_98304;
			`OCRS_M_16E1: main_khz_d = `OCRS_KHZ_131072;
			`OCRS_M_24DS1: main_khz_d = `OCRS_KHZ_148224;
			`OCRS_M_16DS1: main_khz_d = `OCRS_KHZ_98816;
			`OCRS_M_6312: main_khz_d = `OCRS_KHZ_100992;
			default: begin
				main_khz_d = `OCRS_KHZ_NONE;
				err_d[`OCRS_F_E_MAIN] = 1'b1;
			end
		endcase
		err_d[`OCRS_F_E_OUT] = unav;
		// Following without digital feedback loops the aux APLL
		err_d[`OCRS_F_E_DFB] = mctl_q[`OCRS_F_FOLLOW] && !actl_q[`OCRS_F_ADFB];
		follow_d = mctl_q[`OCRS_F_FOLLOW];
		adfb_d = actl_q[`OCRS_F_ADFB];
		frame_d = fsc_q;
		sql_d = 1'b0;
		aux_khz_d = `OCRS_KHZ_NONE;
		if (mctl_q[`OCRS_F_FOLLOW]) begin
			// Aux APLL fed from the main path; aux field ignored
			case (mctl_q[`OCRS_F_M2A])
				`OCRS_T_12E1: aux_khz_d = `OCRS_KHZ_98304;
				`OCRS_T_16E1: aux_khz_d = `OCRS_KHZ_131072;
				`OCRS_T_24DS1: aux_khz_d = `OCRS_KHZ_148224;
				`OCRS_T_16DS1: aux_khz_d = `OCRS_KHZ_98816;
				`OCRS_T_6312: aux_khz_d = `OCRS_KHZ_100992;
				default: begin
					aux_khz_d = `OCRS_KHZ_NONE;
					err_d[`OCRS_F_E_M2A] = 1'b1;
				end
			endcase
		end else begin
			// Independent aux path
			case (actl_q[`OCRS_F_ASEL])
				`OCRS_X_SQL: begin
					aux_khz_d = `OCRS_KHZ_311040;
					sql_d = 1'b1;
				end
				`OCRS_X_NORM: aux_khz_d = `OCRS_KHZ_311040;
				`OCRS_X_12E1: aux_khz_d = `OCRS_KHZ_98304;
				`OCRS_X_16E1: aux_khz_d = `OCRS_KHZ_131072;
				`OCRS_X_24DS1: aux_khz_d = `OCRS_KHZ_148224;
				`OCRS_X_16DS1: aux_khz_d = `OCRS_KHZ_98816;
				`OCRS_X_2E3: aux_khz_d = `OCRS_KHZ_274944;
				`OCRS_X_DS3: aux_khz_d = `OCRS_KHZ_178944;
				`OCRS_X_6312: aux_khz_d = `OCRS_KHZ_100992;
				`OCRS_X_GBE: aux_khz_d = `OCRS_KHZ_250000;
				default: begin
					aux_khz_d = `OCRS_KHZ_NONE;
					err_d[`OCRS_F_E_AUX] = 1'b1;
				end
			endcase
		end
		// Forward synthesis at a quarter of the APLL, only when independent
		fwd_khz_d = mctl_q[`OCRS_F_FOLLOW] ? `OCRS_KHZ_NONE : {2'h0, aux_khz_d[18:2]};
	end

	// Register stage for bus, config and decode
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			mctl_q <= `OCRS_RST_MCTL;
			actl_q <= `OCRS_RST_ACTL;
			ocr_q <= `OCRS_RST_OCR;
			fsc_q <= `OCRS_RST_FSC;
			prdata_q <= 32'h00000000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			main_khz_q <= `OCRS_KHZ_NONE;
			main_afb_q <= 1'b0;
			aux_khz_q <= `OCRS_KHZ_NONE;
			fwd_khz_q <= `OCRS_KHZ_NONE;
			sql_q <= 1'b0;
			follow_q <= 1'b0;
			adfb_q <= 1'b0;
			frame_q <= 1'b0;
			err_q <= 11'h000;
			src_q <= '0;
			div_q <= '0;
		end else begin
			mctl_q <= mctl_d;
			actl_q <= actl_d;
			ocr_q <= ocr_d;
			fsc_q <= fsc_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			main_khz_q <= main_khz_d;
			main_afb_q <= main_afb_d;
			aux_khz_q <= aux_khz_d;
			fwd_khz_q <= fwd_khz_d;
			sql_q <= sql_d;
			follow_q <= follow_d;
			adfb_q <= adfb_d;
			frame_q <= frame_d;
			err_q <= err_d;
			src_q <= src_d;
			div_q <= div_d;
		end
	end

	// Outputs straight from flip-flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign main_apll_khz = main_khz_q;
	assign main_analog_fb = main_afb_q;
	assign aux_apll_khz = aux_khz_q;
	assign aux_fwd_khz = fwd_khz_q;
	assign aux_squelch = sql_q;
	assign aux_from_main = follow_q;
	assign aux_dig_fb = adfb_q;
	assign frame_from_aux = frame_q;
	assign out_src = src_q;
	assign out_div = div_q;
endmodule

// >>> ocrs_monitor.sv
`timescale 1ns/100ps
`include "ocrs_params.svh"
module ocrs_monitor #(
	parameter int N_OUT = 7
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic srst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Path decode
	input wire logic [18:0] main_apll_khz,
	input wire logic main_analog_fb,
	input wire logic [18:0] aux_apll_khz,
	input wire logic [18:0] aux_fwd_khz,
	input wire logic aux_squelch,
	input wire logic aux_from_main,
	input wire logic aux_dig_fb,
	// Output decode
	input wire logic frame_from_aux,
	input wire logic [4*N_OUT-1:0] out_src,
	input wire logic [7*N_OUT-1:0] out_div
);
	// One clock domain for every check
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);

	chk_rdy_setup: assert property (psel && !penable |=> pready)
		else $error("pready missing after setup");
	chk_rdy_single: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	chk_err_rdy: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	// Reset clears outputs one edge later
	chk_reset_clear: assert property (disable iff (1'b0) srst |=> !pready && main_apll_khz == 0)
		else $error("outputs not cleared by reset");
	chk_main_set: assert property (
		main_apll_khz inside {0, `OCRS_KHZ_311040, `OCRS_KHZ_98304, `OCRS_KHZ_131072,
		`OCRS_KHZ_148224, `OCRS_KHZ_98816, `OCRS_KHZ_100992})
		else $error("main rate outside set");
	chk_analog_fb: assert property (
		main_analog_fb |-> main_apll_khz == `OCRS_KHZ_311040)
		else $error("analog feedback with wrong rate");
	chk_fwd_quarter: assert property (
		!aux_from_main |-> aux_fwd_khz == {2'b00, aux_apll_khz[18:2]})
		else $error("aux forward not a quarter");
	chk_follow_fwd: assert property (
		aux_from_main |-> aux_fwd_khz == 0 && !aux_squelch)
		else $error("following aux still forward");
	chk_squelch_rate: assert property (
		aux_squelch |-> aux_apll_khz == `OCRS_KHZ_311040)
		else $error("squelch with wrong rate");
	// Per-output divider sanity
	for (genvar i = 0; i < N_OUT; i++) begin : g_out
		chk_plain_nodiv: assert property (
			out_src[4*i+:4] < 4'h7 |-> out_div[7*i+:7] == 0)
			else $error("divider on non-divided source");
		chk_aux_ratio: assert property (
			out_src[4*i+:4] == 4'h8 |-> out_div[7*i+:7] inside {0, 2, 4, 8, 16, 48, 64})
			else $error("aux ratio not offered");
	end
	// Main scenarios
	cover property (aux_from_main && aux_apll_khz != 0);
	cover property (aux_squelch);
	cover property (pslverr);
endmodule

bind ocrs_top ocrs_monitor #(.N_OUT(N_OUT)) i_ocrs_monitor (.sys_clk(sys_clk), .srst(srst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr), .main_apll_khz(main_apll_khz),
	.main_analog_fb(main_analog_fb), .aux_apll_khz(aux_apll_khz), .aux_fwd_khz(aux_fwd_khz),
	.aux_squelch(aux_squelch), .aux_from_main(aux_from_main), .aux_dig_fb(aux_dig_fb),
	.frame_from_aux(frame_from_aux), .out_src(out_src), .out_div(out_div));

// >>> tb_top.sv
`timescale 1ns/100ps
`include "ocrs_params.svh"
module tb_top;
	// Drive side
	logic sys_clk, srst, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	// Observed side
	logic [31:0] prdata;
	logic pready, pslverr, main_analog_fb, aux_squelch, aux_from_main, aux_dig_fb, frame_from_aux;
	logic [18:0] main_apll_khz, aux_apll_khz, aux_fwd_khz;
	logic [27:0] out_src;
	logic [48:0] out_div;
	// Bookkeeping
	int err_total, n_compared;
	logic [31:0] rd;
	logic err_seen;
	logic [10:0] oc_seen; // Source and divider of one output
	// Divider and source per output code
	localparam logic [6:0] DIVS [16] = '{0, 0, 0, 0, 0, 48, 16, 12, 8, 6, 4, 64, 48, 16, 8, 4};
	localparam logic [3:0] SRCS [16] = '{0, 1, 2, 5, 6, 7, 7, 7, 7, 7, 7, 8, 8, 8, 8, 8};

	ocrs_top #(.N_OUT(7)) i_ocrs_top (.sys_clk(sys_clk), .srst(srst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .main_apll_khz(main_apll_khz),
		.main_analog_fb(main_analog_fb), .aux_apll_khz(aux_apll_khz), .aux_fwd_khz(aux_fwd_khz),
		.aux_squelch(aux_squelch), .aux_from_main(aux_from_main), .aux_dig_fb(aux_dig_fb),
		.frame_from_aux(frame_from_aux), .out_src(out_src), .out_div(out_div));

	// 50 MHz clock
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// Compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One APB transfer, held until pready
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only pready or the watchdog ends a wait
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Write, then let the decode settle
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
		repeat (3) @(posedge sys_clk);
		#1;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask

	// Expected rates in kHz
	function automatic logic [18:0] main_khz(int c);
		case (c)
			0, 1: return `OCRS_KHZ_311040;
			2: return `OCRS_KHZ_98304;
			3: return `OCRS_KHZ_131072;
			4: return `OCRS_KHZ_148224;
			5: return `OCRS_KHZ_98816;
			6: return `OCRS_KHZ_100992;
			default: return 19'h00000;
		endcase
	endfunction

	function automatic logic [18:0] aux_khz(int c);
		case (c)
			0, 1: return `OCRS_KHZ_311040;
			2: return `OCRS_KHZ_98304;
			3: return `OCRS_KHZ_131072;
			4: return `OCRS_KHZ_148224;
			5: return `OCRS_KHZ_98816;
			6: return `OCRS_KHZ_274944;
			7: return `OCRS_KHZ_178944;
			8: return `OCRS_KHZ_100992;
			9: return `OCRS_KHZ_250000;
			default: return 19'h00000;
		endcase
	endfunction

	function automatic logic [18:0] m2a_khz(int c);
		case (c)
			0: return `OCRS_KHZ_98304;
			2: return `OCRS_KHZ_131072;
			4: return `OCRS_KHZ_148224;
			6: return `OCRS_KHZ_98816;
			7: return `OCRS_KHZ_100992;
			default: return 19'h00000;
		endcase
	endfunction

	// Source and divider of output n for code c
	function automatic logic [10:0] exp_out(int n, int c, int f);
		if (n == 6 && c == 3) return {4'h7, 7'h02};
		if (n == 6 && c == 5) return {4'h7, 7'h01};
		if (n == 7 && c == 4) return {4'h7, 7'h02};
		if ((n == 4 || n == 5) && c == 11) return {4'h8, 7'h02};
		if (f == 1 && (c == 1 || c == 2)) return {SRCS[c] + 4'h2, 7'h00};
		return {SRCS[c], DIVS[c]};
	endfunction

	// Verdict
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Watchdog
	initial begin
		#400000;
		err_total++;
		complete_run();
	end

	initial begin
		srst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		err_total = 0;
		n_compared = 0;
		repeat (8) @(posedge sys_clk);
		srst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		#1;
		// Reset values, unmapped and read-only places
		for (int i = 0; i < 7; i++) rdc(12'(4 * i), 32'h0);
		rdc(`OCRS_A_MAIN_STAT, 32'h0004BF00);
		rdc(`OCRS_A_AUX_STAT, 32'h000CBF00);
		rdc(`OCRS_A_ERR_STAT, 32'h0);
		xfer(1'b1, 12'h028, 32'hFFFFFFFF);
		chk(32'(err_seen), 32'h1);
		wr(`OCRS_A_MAIN_STAT, 32'hFFFFFFFF);
		rdc(`OCRS_A_MAIN_STAT, 32'h0004BF00);
		$display("test reset_values done");
		// Every main rate code
		for (int c = 0; c < 8; c++) begin
			wr(`OCRS_A_MAIN_CTRL, 32'(c));
			chk(32'(main_apll_khz), 32'(main_khz(c)));
			chk(32'(main_analog_fb), 32'(c == 1));
			rdc(`OCRS_A_ERR_STAT, 32'(c == 7));
			rdc(`OCRS_A_MAIN_CTRL, 32'(c));
		end
		$display("test main_codes done");
		// Every aux rate code, independent path
		wr(`OCRS_A_MAIN_CTRL, 32'h0);
		for (int c = 0; c < 16; c++) begin
			wr(`OCRS_A_AUX_CTRL, 32'(c));
			chk(32'(aux_apll_khz), 32'(aux_khz(c)));
			chk(32'(aux_fwd_khz), 32'(aux_khz(c) >> 2));
			chk(32'(aux_squelch), 32'(c == 0));
			rdc(`OCRS_A_ERR_STAT, 32'(c > 9) << 1);
		end
		$display("test aux_codes done");
		// Aux follows main; aux code must be ignored
		wr(`OCRS_A_AUX_CTRL, 32'h19);
		for (int c = 0; c < 8; c++) begin
			wr(`OCRS_A_MAIN_CTRL, 32'((c << 4) | 8));
			chk(32'(aux_apll_khz), 32'(m2a_khz(c)));
			chk(32'({aux_from_main, aux_dig_fb}), 32'h3);
			chk(32'(aux_fwd_khz), 32'h0);
			rdc(`OCRS_A_ERR_STAT, (m2a_khz(c) == 0) ? 32'h4 : 32'h0);
		end
		wr(`OCRS_A_AUX_CTRL, 32'h09);
		rdc(`OCRS_A_ERR_STAT, 32'h8);
		$display("test follow_main done");
		// Every output code on every output, both frame sources
		wr(`OCRS_A_MAIN_CTRL, 32'h0);
		wr(`OCRS_A_AUX_CTRL, 32'h1);
		for (int f = 0; f < 2; f++) begin
			wr(`OCRS_A_FSC, 32'(f));
			chk(32'(frame_from_aux), 32'(f));
			for (int n = 1; n < 8; n++) begin
				for (int c = 0; c < 16; c++) begin
					wr(12'(8 + 4 * ((n - 1) / 2)), 32'(c) << (4 * ((n - 1) % 2)));
					oc_seen = {out_src[4*n-4+:4], out_div[7*n-7+:7]};
					chk(32'(oc_seen), 32'(exp_out(n, c, f)));
				end
			end
		end
		rdc(`OCRS_A_ERR_STAT, 32'h0);
		// Reserved main code leaves its divided outputs dead
		wr(`OCRS_A_OUTPUT_CFG_REG_1, 32'hA);
		wr(`OCRS_A_MAIN_CTRL, 32'h7);
		chk(32'({out_src[3:0], out_div[6:0]}), 32'h380);
		$display("test output_codes done");
		complete_run();
	end
endmodule
